// ---- logic/slsb_pkg.sv ----
package slsb_pkg;

    // ********************************************************
    // register indices (byte address is four times the index)
    // ********************************************************
    localparam logic [11:0] IDX_STROBE = 12'h005;
    localparam logic [11:0] IDX_LOCK_STATUS = 12'hd40;
    localparam logic [11:0] IDX_LOOP_STATE = 12'hd41;
    localparam logic [11:0] IDX_LIMIT_FLAGS = 12'hd42;
    localparam logic [11:0] IDX_TUNE_BYTE0 = 12'hd43;
    localparam logic [11:0] IDX_TUNE_BYTE1 = 12'hd44;
    localparam logic [11:0] IDX_TUNE_BYTE2 = 12'hd45;
    localparam logic [11:0] IDX_TUNE_BYTE3 = 12'hd46;
    localparam logic [11:0] IDX_PHASE_BKT_LO = 12'hd47;
    localparam logic [11:0] IDX_PHASE_BKT_HI = 12'hd48;
    localparam logic [11:0] IDX_FREQ_BKT_LO = 12'hd49;
    localparam logic [11:0] IDX_FREQ_BKT_HI = 12'hd4a;

    // value that software writes to the strobe register
    localparam logic [7:0] STROBE_VALUE = 8'h01;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int LOCK_CAL_BIT = 4;
    localparam int LOCK_ANALOG_BIT = 3;
    localparam int LOCK_FREQ_BIT = 2;
    localparam int LOCK_PHASE_BIT = 1;
    localparam int LOCK_ALL_BIT = 0;
    localparam int STATE_REF_LSB = 3;
    localparam int STATE_SWITCH_BIT = 2;
    localparam int STATE_HOLDOVER_BIT = 1;
    localparam int STATE_FREE_RUN_BIT = 0;
    localparam int FLAG_SLEW_BIT = 2;
    localparam int FLAG_CLAMP_BIT = 1;
    localparam int FLAG_HISTORY_BIT = 0;

    // ********************************************************
    // widths, reset values, answers, counts
    // ********************************************************
    localparam int TUNE_WIDTH = 30;
    localparam int BUCKET_WIDTH = 12;
    localparam int SYNC_STAGES = 2;
    localparam logic [29:0] TUNE_RESET = 30'h0000_0000;
    localparam logic [11:0] BUCKET_RESET = 12'h000;
    localparam logic [4:0] LOCK_RESET = 5'h00;
    localparam logic [4:0] STATE_RESET = 5'h00;
    localparam logic [2:0] FLAGS_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- logic/slsb_sync.sv ----
`timescale 1ns/1ps

module slsb_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // levels from the loop domain
    input wire logic [WIDTH-1:0] async_in,
    // levels safe to use on aclk
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } slsb_sync_s;

    slsb_sync_s s;
    slsb_sync_s next_s;

    // first stage feeds only the second stage
    always_comb begin
        next_s = s;
        next_s.first = async_in;
        next_s.second = s.first;
    end

    // register the whole state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.second;

endmodule

// ---- logic/slsb_status_bank.sv ----
`timescale 1ns/1ps

// Summary of operation
// (RQ1) whole status range ignores host writes
// (RQ2) strobe write 0x01 at 0x0005 refreshes snapshot
// (RQ3) lock bit 4 set during oscillator calibration
// (RQ4) lock bit 3 shows analog loop lock
// (RQ5) lock bit 2 shows digital frequency lock
// (RQ6) lock bit 1 shows digital phase lock
// (RQ7) lock bit 0 set only when all locked
// (RQ8) state bits 4:3 give active reference
// (RQ9) state bit 2 set while switching references
// (RQ10) state bit 1 set in holdover
// (RQ11) state bit 0 set in free run
// (RQ12) flags bit 2 set when slew limited
// (RQ13) flags bit 1 set when frequency clamped
// (RQ14) flags bit 0 set when history valid
// (RQ15) tuning word over four bytes, LSB first
// (RQ16) minimal timer gives raw latest tuning word
// (RQ17) phase bucket over two bytes, nibble high
// (RQ18) frequency bucket over two bytes, nibble high
// (RQ19) reserved bits read as zero
// (RQ20) multi-byte fields captured at one instant

module slsb_status_bank #(
    parameter int ADDR_WIDTH = 14
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_WIDTH-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_WIDTH-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // lock levels from the loops
    input wire logic system_loop_locked,
    input wire logic second_analog_loop_locked,
    input wire logic second_analog_loop_cal_busy,
    input wire logic second_digital_loop_freq_locked,
    input wire logic second_digital_loop_phase_locked,
    // mode levels of the second digital loop
    input wire logic [1:0] second_digital_loop_ref_sel,
    input wire logic second_digital_loop_switching,
    input wire logic second_digital_loop_holdover,
    input wire logic second_digital_loop_free_run,
    input wire logic second_digital_loop_slew_limited,
    input wire logic second_digital_loop_freq_clamped,
    input wire logic second_digital_loop_history_valid,
    // tuning words and bucket levels
    input wire logic [29:0] second_digital_loop_avg_word,
    input wire logic [29:0] second_digital_loop_live_word,
    input wire logic history_timer_minimal,
    input wire logic [11:0] second_digital_loop_phase_bucket,
    input wire logic [11:0] second_digital_loop_freq_bucket
);

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic [11:0] aw_idx;
        logic w_held;
        logic [7:0] w_byte;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [4:0] lock;
        logic [4:0] lstate;
        logic [2:0] flags;
        logic [29:0] tune;
        logic [11:0] pbkt;
        logic [11:0] fbkt;
    } slsb_state_s;

    localparam int LIVE_WIDTH = 98;

    slsb_state_s s;
    slsb_state_s next_s;
    logic [LIVE_WIDTH-1:0] live_async;
    logic [LIVE_WIDTH-1:0] live;
    logic sys_lk, ana_lk, ana_cal, dig_fl, dig_pl;
    logic [1:0] dig_ref;
    logic dig_sw, dig_ho, dig_fr, dig_slew, dig_clamp, dig_hist, timer_min;
    logic [29:0] avg_word, live_word;
    logic [11:0] pbkt_live, fbkt_live;
    logic write_go, strobe_hit;
    logic [11:0] ar_idx;
    logic [11:0] aw_idx_in;

    // ********************************************************
    // input crossing
    // ********************************************************
    // the loops run on their own clocks; every level is synchronised first
    assign live_async = {system_loop_locked, second_analog_loop_locked,
                         second_analog_loop_cal_busy, second_digital_loop_freq_locked,
                         second_digital_loop_phase_locked, second_digital_loop_ref_sel,
                         second_digital_loop_switching, second_digital_loop_holdover,
                         second_digital_loop_free_run, second_digital_loop_slew_limited,
                         second_digital_loop_freq_clamped, second_digital_loop_history_valid,
                         second_digital_loop_avg_word, second_digital_loop_live_word,
                         history_timer_minimal, second_digital_loop_phase_bucket,
                         second_digital_loop_freq_bucket};

    slsb_sync #(
        .WIDTH(LIVE_WIDTH)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(live_async),
        .sync_out(live)
    );

    // unpack the synchronised levels
    assign {sys_lk, ana_lk, ana_cal, dig_fl, dig_pl, dig_ref, dig_sw, dig_ho, dig_fr,
            dig_slew, dig_clamp, dig_hist, avg_word, live_word, timer_min,
            pbkt_live, fbkt_live} = live;

    // ********************************************************
    // address decode
    // ********************************************************
    // word index from a byte address; the two low bits are ignored
    function automatic logic [11:0] word_index(input logic [ADDR_WIDTH-1:0] addr);
        return addr[13:2];
    endfunction

    // true for any index inside the status range
    function automatic logic in_status(input logic [11:0] idx);
        return (idx >= slsb_pkg::IDX_LOCK_STATUS) && (idx <= slsb_pkg::IDX_FREQ_BKT_HI);
    endfunction

    // read answer {resp, data}; upper bits and reserved bits read zero
    function automatic logic [33:0] read_word(input logic [11:0] idx, input slsb_state_s st);
        logic [7:0] b;
        logic [1:0] resp;
        b = 8'h00;
        resp = slsb_pkg::RESP_OKAY;
        if (idx == slsb_pkg::IDX_STROBE) begin
            b = 8'h00;
        end else if (idx == slsb_pkg::IDX_LOCK_STATUS) begin
            b = {3'h0, st.lock};
        end else if (idx == slsb_pkg::IDX_LOOP_STATE) begin
            b = {3'h0, st.lstate};
        end else if (idx == slsb_pkg::IDX_LIMIT_FLAGS) begin
            b = {5'h00, st.flags};
        end else if (idx == slsb_pkg::IDX_TUNE_BYTE0) begin
            b = st.tune[7:0];
        end else if (idx == slsb_pkg::IDX_TUNE_BYTE1) begin
            b = st.tune[15:8];
        end else if (idx == slsb_pkg::IDX_TUNE_BYTE2) begin
            b = st.tune[23:16];
        end else if (idx == slsb_pkg::IDX_TUNE_BYTE3) begin
            b = {2'h0, st.tune[29:24]};
        end else if (idx == slsb_pkg::IDX_PHASE_BKT_LO) begin
            b = st.pbkt[7:0];
        end else if (idx == slsb_pkg::IDX_PHASE_BKT_HI) begin
            b = {4'h0, st.pbkt[11:8]};
        end else if (idx == slsb_pkg::IDX_FREQ_BKT_LO) begin
            b = st.fbkt[7:0];
        end else if (idx == slsb_pkg::IDX_FREQ_BKT_HI) begin
            b = {4'h0, st.fbkt[11:8]};
        end else begin
            resp = slsb_pkg::RESP_SLVERR;
        end
        return {resp, 24'h00_0000, b};
    endfunction

    assign ar_idx = word_index(araddr);
    assign aw_idx_in = word_index(awaddr);
    assign write_go = s.aw_held && s.w_held && !s.bvalid;
    assign strobe_hit = write_go && (s.aw_idx == slsb_pkg::IDX_STROBE) && s.w_lane0 &&
                        (s.w_byte == slsb_pkg::STROBE_VALUE);

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        next_s = s;
        // address and data are taken in either order and held until both are here
        if (awvalid && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_idx = aw_idx_in;
        end
        if (wvalid && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.w_byte = wdata[7:0];
            next_s.w_lane0 = wstrb[0];
        end
        // write completes one cycle after both halves are held
        if (write_go) begin
            next_s.bvalid = 1'b1;
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bresp = slsb_pkg::RESP_OKAY;
            if (s.aw_idx != slsb_pkg::IDX_STROBE && !in_status(s.aw_idx)) begin
                next_s.bresp = slsb_pkg::RESP_SLVERR;
            end
        end else if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        // (RQ2) strobe captures snapshot
        // (RQ20) one-instant capture; every field loads on the same edge
        if (strobe_hit) begin
            // (RQ3) calibration busy bit
            next_s.lock[slsb_pkg::LOCK_CAL_BIT] = ana_cal;
            // (RQ4) analog loop lock
            next_s.lock[slsb_pkg::LOCK_ANALOG_BIT] = ana_lk;
            // (RQ5) frequency lock bit
            next_s.lock[slsb_pkg::LOCK_FREQ_BIT] = dig_fl;
            // (RQ6) phase lock bit
            next_s.lock[slsb_pkg::LOCK_PHASE_BIT] = dig_pl;
            // (RQ7) all-locked summary
            next_s.lock[slsb_pkg::LOCK_ALL_BIT] = sys_lk && ana_lk && dig_pl && dig_fl;
            // (RQ8) active reference code
            next_s.lstate[slsb_pkg::STATE_REF_LSB +: 2] = dig_ref;
            // (RQ9) switching bit
            next_s.lstate[slsb_pkg::STATE_SWITCH_BIT] = dig_sw;
            // (RQ10) holdover bit
            next_s.lstate[slsb_pkg::STATE_HOLDOVER_BIT] = dig_ho;
            // (RQ11) free run bit
            next_s.lstate[slsb_pkg::STATE_FREE_RUN_BIT] = dig_fr;
            // (RQ12) slew limit flag
            next_s.flags[slsb_pkg::FLAG_SLEW_BIT] = dig_slew;
            // (RQ13) frequency clamp flag
            next_s.flags[slsb_pkg::FLAG_CLAMP_BIT] = dig_clamp;
            // (RQ14) history valid flag
            next_s.flags[slsb_pkg::FLAG_HISTORY_BIT] = dig_hist;
            // (RQ16) raw word when timer minimal
            next_s.tune = timer_min ? live_word : avg_word;
            // (RQ17) phase bucket level
            next_s.pbkt = pbkt_live;
            // (RQ18) frequency bucket level
            next_s.fbkt = fbkt_live;
        end
        // one read at a time; answer one cycle after the address is taken
        // (RQ15) (RQ19) byte layout and zero reserved bits come from the read decode
        if (arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            {next_s.rresp, next_s.rdata} = read_word(ar_idx, s);
        end else if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        // ready flags are registered so that every output comes from a flop
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready = !next_s.w_held && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    // ********************************************************
    // state register
    // ********************************************************
    // (RQ1) writes only reach the snapshot through the strobe path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.lock <= slsb_pkg::LOCK_RESET;
            s.lstate <= slsb_pkg::STATE_RESET;
            s.flags <= slsb_pkg::FLAGS_RESET;
            s.tune <= slsb_pkg::TUNE_RESET;
            s.pbkt <= slsb_pkg::BUCKET_RESET;
            s.fbkt <= slsb_pkg::BUCKET_RESET;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic ar_fire;
    assign ar_fire = arvalid && s.arready;

    ro_write_a: assert property ( // RQ1
        (write_go && in_status(s.aw_idx)) |=>
            ($stable(s.lock) && $stable(s.tune) && $stable(s.pbkt) && $stable(s.fbkt))
    ) else $error("write changed the status snapshot");

    strobe_snap_a: assert property ( // RQ2
        strobe_hit |=> (s.lstate == {$past(dig_ref), $past(dig_sw), $past(dig_ho),
                                     $past(dig_fr)})
    ) else $error("strobe did not capture loop state");

    cal_read_a: assert property ( // RQ3
        (ar_fire && ar_idx == slsb_pkg::IDX_LOCK_STATUS) |=>
            (rvalid && rdata[4] == s.lock[slsb_pkg::LOCK_CAL_BIT])
    ) else $error("calibration bit not returned on read");

    all_lock_a: assert property ( // RQ7
        (strobe_hit && !sys_lk) |=> !s.lock[slsb_pkg::LOCK_ALL_BIT]
    ) else $error("all-locked set while system loop unlocked");

    reserved_zero_a: assert property ( // RQ19
        (ar_fire && ar_idx == slsb_pkg::IDX_LOCK_STATUS) |=> (rdata[31:5] == 27'h0)
    ) else $error("reserved lock bits not zero");

    tune_top_a: assert property ( // RQ15
        (ar_fire && ar_idx == slsb_pkg::IDX_TUNE_BYTE3) |=>
            (rdata[7:0] == {2'h0, s.tune[29:24]})
    ) else $error("tuning word top byte wrong");

    raw_word_a: assert property ( // RQ16
        (strobe_hit && timer_min) |=> (s.tune == $past(live_word))
    ) else $error("minimal timer did not give raw word");

    phase_high_a: assert property ( // RQ17
        (ar_fire && ar_idx == slsb_pkg::IDX_PHASE_BKT_HI) |=>
            (rdata[7:0] == {4'h0, s.pbkt[11:8]})
    ) else $error("phase bucket high nibble wrong");

    freq_low_a: assert property ( // RQ18
        (ar_fire && ar_idx == slsb_pkg::IDX_FREQ_BKT_LO) |=> (rdata[7:0] == s.fbkt[7:0])
    ) else $error("frequency bucket low byte wrong");

endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps

`define CHK(name, exp, got) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("unexpected %s expected %h seen %h", name, exp, got); \
    end \
end

module tb_top;

    // ********************************************************
    // clock, reset and bus signals
    // ********************************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
    logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
    logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp;

    // loop levels, all driven by the bench
    logic system_loop_locked = 1'b0, second_analog_loop_locked = 1'b0;
    logic second_analog_loop_cal_busy = 1'b0, second_digital_loop_freq_locked = 1'b0;
    logic second_digital_loop_phase_locked = 1'b0, second_digital_loop_switching = 1'b0;
    logic second_digital_loop_holdover = 1'b0, second_digital_loop_free_run = 1'b0;
    logic second_digital_loop_slew_limited = 1'b0, second_digital_loop_freq_clamped = 1'b0;
    logic second_digital_loop_history_valid = 1'b0, history_timer_minimal = 1'b0;
    logic [1:0] second_digital_loop_ref_sel = 2'h0;
    logic [29:0] second_digital_loop_avg_word = 30'h0, second_digital_loop_live_word = 30'h0;
    logic [11:0] second_digital_loop_phase_bucket = 12'h000;
    logic [11:0] second_digital_loop_freq_bucket = 12'h000;

    // expected snapshot, one byte per status register
    logic [7:0] snap [11];
    int err_count = 0;
    int compares = 0;

    slsb_status_bank i_slsb_status_bank (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid,
        .rready, .rdata, .rresp, .system_loop_locked, .second_analog_loop_locked,
        .second_analog_loop_cal_busy, .second_digital_loop_freq_locked,
        .second_digital_loop_phase_locked, .second_digital_loop_ref_sel,
        .second_digital_loop_switching, .second_digital_loop_holdover,
        .second_digital_loop_free_run, .second_digital_loop_slew_limited,
        .second_digital_loop_freq_clamped, .second_digital_loop_history_valid,
        .second_digital_loop_avg_word, .second_digital_loop_live_word,
        .history_timer_minimal, .second_digital_loop_phase_bucket,
        .second_digital_loop_freq_bucket
    );

    // 100 mhz clock
    initial begin
        forever #5 aclk = ~aclk;
    end

    // ********************************************************
    // bus tasks, entered right after a rising edge
    // ********************************************************
    task automatic axi_write(input logic [11:0] idx, input logic [7:0] data,
                             output logic [1:0] resp);
        int n;
        n = 0;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, data};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // address and data may be taken at different edges
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 50);
        resp = bresp;
        bready <= 1'b0;
        `CHK("write answer", 1'b1, n < 50)
        // let an edge pass so a following write never re-raises bready in this step
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [11:0] idx, output logic [31:0] data,
                            output logic [1:0] resp);
        int n;
        n = 0;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 50);
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
        `CHK("read answer", 1'b1, n < 50)
        // let an edge pass so a following read never re-raises rready in this step
        @(posedge aclk);
    endtask

    // let the synchronisers settle, then refresh and note what should be captured
    task automatic strobe();
        logic [1:0] r;
        logic [29:0] w;
        repeat (4) @(posedge aclk);
        w = history_timer_minimal ? second_digital_loop_live_word : second_digital_loop_avg_word;
        snap[0] = {3'h0, second_analog_loop_cal_busy, second_analog_loop_locked,
                   second_digital_loop_freq_locked, second_digital_loop_phase_locked,
                   system_loop_locked & second_analog_loop_locked &
                   second_digital_loop_freq_locked & second_digital_loop_phase_locked};
        snap[1] = {3'h0, second_digital_loop_ref_sel, second_digital_loop_switching,
                   second_digital_loop_holdover, second_digital_loop_free_run};
        snap[2] = {5'h00, second_digital_loop_slew_limited, second_digital_loop_freq_clamped,
                   second_digital_loop_history_valid};
        snap[3] = w[7:0];
        snap[4] = w[15:8];
        snap[5] = w[23:16];
        snap[6] = {2'h0, w[29:24]};
        snap[7] = second_digital_loop_phase_bucket[7:0];
        snap[8] = {4'h0, second_digital_loop_phase_bucket[11:8]};
        snap[9] = second_digital_loop_freq_bucket[7:0];
        snap[10] = {4'h0, second_digital_loop_freq_bucket[11:8]};
        axi_write(slsb_pkg::IDX_STROBE, slsb_pkg::STROBE_VALUE, r);
        `CHK("strobe resp", slsb_pkg::RESP_OKAY, r)
    endtask

    task automatic check_reg(input int i);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(slsb_pkg::IDX_LOCK_STATUS + 12'(i), d, r);
        `CHK("status byte", {24'h000000, snap[i]}, d)
        `CHK("status resp", slsb_pkg::RESP_OKAY, r)
    endtask

    task automatic check_bank();
        for (int i = 0; i < 11; i++) begin
            check_reg(i);
        end
    endtask

    // ********************************************************
    // scenarios
    // ********************************************************
    // every combination of lock levels and calibration
    task automatic t_lock();
        for (int i = 0; i < 32; i++) begin
            {system_loop_locked, second_analog_loop_locked, second_analog_loop_cal_busy,
             second_digital_loop_freq_locked, second_digital_loop_phase_locked} <= 5'(i);
            strobe();
            // lock byte tracks calibration and locks
            check_reg(0);
        end
    endtask

    // all references and modes, plus the limit and history flags
    task automatic t_state();
        for (int i = 0; i < 32; i++) begin
            {second_digital_loop_ref_sel, second_digital_loop_switching,
             second_digital_loop_holdover, second_digital_loop_free_run} <= 5'(i);
            {second_digital_loop_slew_limited, second_digital_loop_freq_clamped,
             second_digital_loop_history_valid} <= 3'(i);
            strobe();
            check_reg(1);
            check_reg(2);
        end
    endtask

    // averaged word, then the raw latest word with the minimal timer
    task automatic t_words();
        second_digital_loop_avg_word <= 30'h2a5c_3e71;
        second_digital_loop_live_word <= 30'h15a3_c18e;
        second_digital_loop_phase_bucket <= 12'hfed;
        second_digital_loop_freq_bucket <= 12'h9b7;
        strobe();
        check_bank();
        history_timer_minimal <= 1'b1;
        strobe();
        check_bank();
    endtask

    // snapshot holds against input changes, bad strobes and host writes
    task automatic t_hold();
        logic [31:0] d;
        logic [1:0] r;
        second_digital_loop_avg_word <= 30'h3fff_ffff;
        second_digital_loop_live_word <= 30'h0000_0001;
        second_digital_loop_phase_bucket <= 12'h123;
        second_digital_loop_freq_bucket <= 12'h456;
        system_loop_locked <= ~system_loop_locked;
        repeat (4) @(posedge aclk);
        axi_write(slsb_pkg::IDX_STROBE, 8'h02, r);
        `CHK("other strobe data resp", slsb_pkg::RESP_OKAY, r)
        for (int i = 0; i < 11; i++) begin
            axi_write(slsb_pkg::IDX_LOCK_STATUS + 12'(i), 8'hff, r);
            `CHK("status write resp", slsb_pkg::RESP_OKAY, r)
        end
        check_bank();
        axi_write(12'h100, 8'h01, r);
        `CHK("unmapped write resp", slsb_pkg::RESP_SLVERR, r)
        axi_read(12'h100, d, r);
        `CHK("unmapped read resp", slsb_pkg::RESP_SLVERR, r)
        `CHK("unmapped read data", 32'h0000_0000, d)
        axi_read(slsb_pkg::IDX_STROBE, d, r);
        `CHK("strobe read data", 32'h0000_0000, d)
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        for (int i = 0; i < 11; i++) begin
            snap[i] = 8'h00;
        end
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        // nothing captured before the first strobe
        check_bank();
        t_lock();
        t_state();
        t_words();
        t_hold();
        summarize();
    end

    // watchdog, well beyond the roughly one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        summarize();
    end

endmodule
